// *** pkg/cspc_pkg.sv ***
// Constants and types shared by the configuration start-up pin controller.
package cspc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the AHB-Lite bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] CSPC_CTRL_ADDR = 8'h00;
	localparam logic [7:0] CSPC_TIMING_ADDR = 8'h04;
	localparam logic [7:0] CSPC_STATUS_ADDR = 8'h08;
	localparam logic [7:0] CSPC_CLKDIV_ADDR = 8'h0C;
	localparam logic [7:0] CSPC_UNUSED_ADDR = 8'h10;
	localparam logic [7:0] CSPC_CMD_ADDR = 8'h14;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CSPC_CTRL_RB_EN = 0;
	localparam int CSPC_CTRL_TS_KEEP = 1;
	localparam int CSPC_CTRL_GSR_EN = 2;
	localparam int CSPC_CTRL_GSR_SET = 3;
	localparam int CSPC_CMD_LOADED = 0;
	localparam int CSPC_CMD_CLEARED = 1;
	localparam int CSPC_TIM_DONE_LSB = 0;
	localparam int CSPC_TIM_REL_LSB = 8;
	localparam int CSPC_ST_STATE_LSB = 0;
	localparam int CSPC_ST_MODE_LSB = 4;
	localparam int CSPC_ST_DONE = 7;
	localparam int CSPC_ST_RB = 8;
	localparam int CSPC_ST_TS = 9;
	localparam int CSPC_ST_FRAME_LSB = 16;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] CSPC_CTRL_RST = 4'h0;
	localparam logic [15:0] CSPC_TIMING_RST = 16'h0101;
	localparam logic [7:0] CSPC_CLKDIV_RST = 8'h04;
	localparam logic [31:0] CSPC_UNUSED_RST = 32'h00000000;

	// ----------------------------------------------------------------
	// Configuration modes sampled from the mode-select pins
	// ----------------------------------------------------------------
	localparam logic [2:0] CSPC_MODE_MSTR_SER = 3'h0;
	localparam logic [2:0] CSPC_MODE_MSTR_PAR = 3'h2;
	localparam logic [2:0] CSPC_MODE_SYNC_PER = 3'h3;
	localparam logic [2:0] CSPC_MODE_MICRO = 3'h4;
	localparam logic [2:0] CSPC_MODE_ASYNC_PER = 3'h5;
	localparam logic [2:0] CSPC_MODE_SLV_PAR = 3'h6;
	localparam logic [2:0] CSPC_MODE_SLV_SER = 3'h7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CSPC_READBACK_ABORT_CONFIG_CLOCK = 2;
	localparam int CSPC_FRAME_BITS = 32;

	typedef enum logic [3:0] {
		CSPC_CLEAR,
		CSPC_WAIT_INIT,
		CSPC_LOAD,
		CSPC_DONE_DLY,
		CSPC_DONE_WAIT,
		CSPC_RELEASE,
		CSPC_USER
	} cspc_state_t;

endpackage

// *** src/cspc_ctrl.sv ***
// Configuration and start-up pin controller with an AHB-Lite register port.
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps

module cspc_ctrl
	import cspc_pkg::*;
#(
	parameter int USER_IO = 32,
	parameter int CLEAR_CYCLES = 64
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic config_restart_n,
	input wire logic reset_pin_n,
	input wire logic readback_trigger_n,
	input wire logic done_in,
	output logic done_out,
	output logic done_oe_n,
	input wire logic init_in,
	output logic init_out,
	output logic init_oe_n,
	input wire logic [2:0] config_mode_select,
	output logic mode_pullup_en,
	output logic config_clock_out,
	output logic config_clock_oe_n,
	input wire logic tdo_in,
	input wire logic scan_active,
	output logic readback_data_tdo,
	output logic [7:0] rb_frame_addr,
	input wire logic [31:0] rb_frame_data,
	output logic bscan_reset,
	output logic global_io_tristate,
	input wire logic [USER_IO-1:0] user_oe_n,
	output logic [USER_IO-1:0] programmable_io_oe_n,
	output logic [USER_IO-1:0] programmable_io_pullup,
	output logic config_pins_released,
	output logic reset_pin_user,
	output logic logic_cell_gsr,
	output logic logic_cell_gsr_set
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Stage one feeds stage two only; all but init reset high (pull-ups).
	logic [4:0] pin_raw;
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic restart_n_s, reset_n_s, rb_n_s, done_s, init_s;

	assign pin_raw = {init_in, done_in, readback_trigger_n, reset_pin_n,
		config_restart_n};
	always_ff @(posedge clock) begin
		if (rst) begin
			sync1_q <= 5'h0F;
			sync2_q <= 5'h0F;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end
	assign restart_n_s = sync2_q[0];
	assign reset_n_s = sync2_q[1];
	assign rb_n_s = sync2_q[2];
	assign done_s = sync2_q[3];
	assign init_s = sync2_q[4];

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [3:0] ctrl_q;
	logic [15:0] timing_q;
	logic [7:0] clkdiv_q;
	logic [USER_IO-1:0] unused_q;
	logic loaded_pulse, cleared_pulse;
	logic ap_wr_q, ap_rd_q;
	logic [7:0] ap_addr_q;
	logic ap_valid;
	logic [31:0] status;
	cspc_state_t state_q;
	logic [2:0] mode_q;
	logic rb_active_q;
	logic [7:0] frame_q;

	assign ap_valid = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge clock) begin
		if (rst) begin
			ap_wr_q <= 1'b0;
			ap_rd_q <= 1'b0;
			ap_addr_q <= 8'h00;
		end else if (hready) begin
			ap_wr_q <= ap_valid && hwrite;
			ap_rd_q <= ap_valid && !hwrite;
			ap_addr_q <= haddr[7:0];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q <= CSPC_CTRL_RST;
			timing_q <= CSPC_TIMING_RST;
			clkdiv_q <= CSPC_CLKDIV_RST;
			unused_q <= USER_IO'(CSPC_UNUSED_RST);
		end else if (ap_wr_q) begin
			unique case (ap_addr_q)
			CSPC_CTRL_ADDR: ctrl_q <= hwdata[3:0];
			CSPC_TIMING_ADDR: timing_q <= hwdata[15:0];
			CSPC_CLKDIV_ADDR: clkdiv_q <= hwdata[7:0];
			CSPC_UNUSED_ADDR: unused_q <= hwdata[USER_IO-1:0];
			default: ;
			endcase
		end
	end

	assign loaded_pulse = ap_wr_q && (ap_addr_q == CSPC_CMD_ADDR) &&
		hwdata[CSPC_CMD_LOADED];
	assign cleared_pulse = ap_wr_q && (ap_addr_q == CSPC_CMD_ADDR) &&
		hwdata[CSPC_CMD_CLEARED];

	always_comb begin
		status = 32'h00000000;
		status[CSPC_ST_STATE_LSB +: 4] = state_q;
		status[CSPC_ST_MODE_LSB +: 3] = mode_q;
		status[CSPC_ST_DONE] = done_s;
		status[CSPC_ST_RB] = rb_active_q;
		status[CSPC_ST_TS] = global_io_tristate;
		status[CSPC_ST_FRAME_LSB +: 8] = frame_q;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (hready) begin
			hrdata <= 32'h00000000;
			if (ap_valid && !hwrite) begin
				unique case (haddr[7:0])
				CSPC_CTRL_ADDR: hrdata <= {28'h0000000, ctrl_q};
				CSPC_TIMING_ADDR: hrdata <= {16'h0000, timing_q};
				CSPC_STATUS_ADDR: hrdata <= status;
				CSPC_CLKDIV_ADDR: hrdata <= {24'h000000, clkdiv_q};
				CSPC_UNUSED_ADDR: hrdata <= 32'(unused_q);
				default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration clock divider
	// ----------------------------------------------------------------
	logic [7:0] div_cnt_q;
	logic config_clock_en;
	logic config_clock_q;
	logic drive_config_clock;

	assign config_clock_en = (div_cnt_q == 8'h00);
	always_ff @(posedge clock) begin
		if (rst || config_clock_en) begin
			div_cnt_q <= (clkdiv_q == 8'h00) ? 8'h00 : clkdiv_q - 8'h01;
		end else begin
			div_cnt_q <= div_cnt_q - 8'h01;
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			config_clock_q <= 1'b0;
		end else if (config_clock_en) begin
			config_clock_q <= !config_clock_q;
		end
	end
	// Slave and synchronous peripheral modes leave the pin to the host.
	assign drive_config_clock = (mode_q == CSPC_MODE_MSTR_SER) ||
		(mode_q == CSPC_MODE_MSTR_PAR) || (mode_q == CSPC_MODE_ASYNC_PER) ||
		(mode_q == CSPC_MODE_MICRO);
	assign config_clock_out = config_clock_q;
	assign config_clock_oe_n = !(drive_config_clock && state_q == CSPC_LOAD);

	// ----------------------------------------------------------------
	// Configuration state machine
	// ----------------------------------------------------------------
	logic init_s_q;
	logic restart_req;
	logic [7:0] dly_q;
	logic [$clog2(CLEAR_CYCLES+1)-1:0] clr_q;
	logic tick;
	logic in_config;

	// A tick is one full configuration clock period.
	assign tick = config_clock_en && config_clock_q;
	assign restart_req = !restart_n_s ||
		(!reset_n_s && state_q != CSPC_USER);
	assign in_config = (state_q != CSPC_USER);

	always_ff @(posedge clock) begin
		if (rst) begin
			init_s_q <= 1'b1;
		end else begin
			init_s_q <= init_s;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || restart_req) begin
			state_q <= CSPC_CLEAR;
			clr_q <= '0;
			dly_q <= 8'h00;
		end else begin
			unique case (state_q)
			CSPC_CLEAR: begin
				// Memory clear ends on software word or timeout.
				clr_q <= clr_q + 1'b1;
				if (cleared_pulse || clr_q == CLEAR_CYCLES[$bits(clr_q)-1:0]) begin
					state_q <= CSPC_WAIT_INIT;
				end
			end
			CSPC_WAIT_INIT: begin
				if (init_s && !init_s_q) begin
					state_q <= CSPC_LOAD;
				end
			end
			CSPC_LOAD: begin
				if (loaded_pulse) begin
					state_q <= CSPC_DONE_DLY;
					dly_q <= timing_q[CSPC_TIM_DONE_LSB +: 8];
				end
			end
			CSPC_DONE_DLY: begin
				if (dly_q == 8'h00) begin
					state_q <= CSPC_DONE_WAIT;
				end else if (tick) begin
					dly_q <= dly_q - 8'h01;
				end
			end
			CSPC_DONE_WAIT: begin
				if (done_s) begin
					state_q <= CSPC_RELEASE;
					dly_q <= timing_q[CSPC_TIM_REL_LSB +: 8];
				end
			end
			CSPC_RELEASE: begin
				if (dly_q == 8'h00) begin
					state_q <= CSPC_USER;
				end else if (tick) begin
					dly_q <= dly_q - 8'h01;
				end
			end
			CSPC_USER: ;
			endcase
		end
	end

	// Mode is latched only on the init rising edge seen while waiting.
	always_ff @(posedge clock) begin
		if (rst) begin
			mode_q <= CSPC_MODE_SLV_SER;
		end else if (state_q == CSPC_WAIT_INIT && init_s && !init_s_q &&
				!restart_req) begin
			mode_q <= config_mode_select;
		end
	end

	// ----------------------------------------------------------------
	// Open-drain init and completion pins
	// ----------------------------------------------------------------
	assign init_out = 1'b0;
	assign init_oe_n = (state_q != CSPC_CLEAR);
	assign done_out = 1'b0;
	assign done_oe_n = (state_q == CSPC_DONE_WAIT) ||
		(state_q == CSPC_RELEASE) || (state_q == CSPC_USER);

	// ----------------------------------------------------------------
	// Readback
	// ----------------------------------------------------------------
	logic rb_n_q;
	logic [4:0] bit_q;
	logic [1:0] abort_q;
	logic rb_fall;

	assign rb_fall = rb_n_q && !rb_n_s;
	always_ff @(posedge clock) begin
		if (rst) begin
			rb_n_q <= 1'b1;
		end else begin
			rb_n_q <= rb_n_s;
		end
	end

	// The trigger held high for two configuration clock periods aborts readback.
	always_ff @(posedge clock) begin
		if (rst || state_q != CSPC_USER) begin
			rb_active_q <= 1'b0;
			frame_q <= 8'h00;
			bit_q <= 5'h00;
			abort_q <= 2'h0;
		end else if (rb_fall && ctrl_q[CSPC_CTRL_RB_EN]) begin
			rb_active_q <= 1'b1;
			frame_q <= 8'h00;
			bit_q <= 5'h00;
			abort_q <= 2'h0;
		end else if (rb_active_q && tick) begin
			bit_q <= bit_q + 5'h01;
			if (bit_q == 5'(CSPC_FRAME_BITS - 1)) begin
				frame_q <= frame_q + 8'h01;
			end
			abort_q <= rb_n_s ? abort_q + 2'h1 : 2'h0;
			if (rb_n_s && abort_q == 2'(CSPC_READBACK_ABORT_CONFIG_CLOCK - 1)) begin
				rb_active_q <= 1'b0;
			end
		end
	end
	assign rb_frame_addr = frame_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			readback_data_tdo <= 1'b0;
		end else if (scan_active) begin
			readback_data_tdo <= tdo_in;
		end else begin
			readback_data_tdo <= rb_active_q && rb_frame_data[bit_q];
		end
	end

	// ----------------------------------------------------------------
	// I/O control
	// ----------------------------------------------------------------
	assign global_io_tristate = !rb_n_s && (in_config ||
		(ctrl_q[CSPC_CTRL_TS_KEEP] && !ctrl_q[CSPC_CTRL_RB_EN]));
	assign bscan_reset = !restart_n_s;
	assign mode_pullup_en = in_config;
	assign config_pins_released = !in_config;

	for (genvar i = 0; i < USER_IO; i++) begin : g_io
		assign programmable_io_oe_n[i] = in_config || global_io_tristate ||
			unused_q[i] || user_oe_n[i];
		assign programmable_io_pullup[i] = in_config || unused_q[i];
	end

	assign reset_pin_user = !in_config && !reset_n_s;
	assign logic_cell_gsr = !in_config && ctrl_q[CSPC_CTRL_GSR_EN] &&
		!reset_n_s;
	assign logic_cell_gsr_set = ctrl_q[CSPC_CTRL_GSR_SET];

endmodule

// *** testbench/cspc_props.sv ***
// Concurrent checks on the pin side of the start-up pin controller.
`timescale 1ns/1ps
module cspc_props
	import cspc_pkg::*;
#(
	parameter int USER_IO = 32
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic config_restart_n,
	input wire logic reset_pin_n,
	input wire logic readback_trigger_n,
	input wire logic done_in,
	input wire logic done_out,
	input wire logic done_oe_n,
	input wire logic init_oe_n,
	input wire logic mode_pullup_en,
	input wire logic tdo_in,
	input wire logic scan_active,
	input wire logic readback_data_tdo,
	input wire logic bscan_reset,
	input wire logic global_io_tristate,
	input wire logic [USER_IO-1:0] programmable_io_oe_n,
	input wire logic [USER_IO-1:0] programmable_io_pullup,
	input wire logic config_pins_released
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	AST_IO_FLOAT: assert property (
		!config_pins_released |-> &programmable_io_oe_n
		&& &programmable_io_pullup) else $error("pins active in config");
	AST_RESTART: assert property (
		$fell(config_restart_n) |-> ##[1:6] !init_oe_n && bscan_reset)
		else $error("restart input ignored");
	AST_RESET_PIN: assert property (
		$fell(reset_pin_n) && !config_pins_released |-> ##[1:6] !init_oe_n)
		else $error("reset pin did not restart loading");
	AST_DONE_OD: assert property (
		config_pins_released |-> done_oe_n && !done_out)
		else $error("done pin pulled after start-up");
	AST_DONE_CLEAR: assert property (
		!init_oe_n |-> !done_oe_n) else $error("done released while clearing");
	AST_DONE_HOLD: assert property (
		(!done_in)[*4] |=> !$rose(config_pins_released))
		else $error("start-up while done pin held low");
	AST_TS_CONFIG: assert property (
		(!readback_trigger_n)[*4] ##0 !config_pins_released
		|-> global_io_tristate) else $error("trigger did not tri-state");
	AST_MODE_PU: assert property (
		mode_pullup_en != config_pins_released)
		else $error("mode pull-up wrong for phase");
	AST_SHARED_TDO: assert property (
		scan_active |=> readback_data_tdo == $past(tdo_in))
		else $error("scan data not on shared pin");

	cover property ($rose(config_pins_released));
	cover property (global_io_tristate && !config_pins_released);
	cover property (scan_active);
endmodule

bind cspc_ctrl cspc_props #(.USER_IO(USER_IO)) u_props (.clock, .rst,
	.config_restart_n, .reset_pin_n, .readback_trigger_n, .done_in,
	.done_out, .done_oe_n, .init_oe_n, .mode_pullup_en, .tdo_in,
	.scan_active, .readback_data_tdo, .bscan_reset, .global_io_tristate,
	.programmable_io_oe_n, .programmable_io_pullup, .config_pins_released);

// *** testbench/cspc_host.sv ***
// Board-side host model for the open-drain and trigger pins.
`timescale 1ns/1ps
module cspc_host (
	input wire logic clock,
	input wire logic rst,
	input wire logic done_oe_n,
	input wire logic init_oe_n,
	input wire logic hold_done,
	input wire logic hold_init,
	input wire logic trig_req_n,
	output logic done_in,
	output logic init_in,
	output logic readback_trigger_n
);
	logic init_seen_q;

	// Both pins have pull-ups, so the wire is the AND of all pullers.
	assign done_in = done_oe_n & !hold_done;
	assign init_in = init_oe_n & !hold_init;
	always_ff @(posedge clock) begin
		if (rst || !init_oe_n)
			init_seen_q <= 1'b0;
		else if (init_in)
			init_seen_q <= 1'b1;
	end
	// A low request is withheld until init has come up once.
	assign readback_trigger_n = trig_req_n | !init_seen_q;
endmodule

// *** testbench/tb_top.sv ***
// Self-checking testbench for the configuration start-up pin controller.
`timescale 1ns/1ps
module tb_top
	import cspc_pkg::*;
;
	logic clock, rst, hwrite, hready, hreadyout, hresp, rd_ph, tdo_in;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rb_frame_data, user_oe_n, msk;
	logic [31:0] programmable_io_oe_n, programmable_io_pullup;
	logic config_restart_n, reset_pin_n, readback_trigger_n, done_in;
	logic done_out, done_oe_n, init_in, init_out, init_oe_n;
	logic config_clock_out, config_clock_oe_n, scan_active, mode_pullup_en;
	logic readback_data_tdo, bscan_reset, global_io_tristate;
	logic config_pins_released, reset_pin_user, logic_cell_gsr;
	logic logic_cell_gsr_set, hold_done, hold_init, trig_req_n;
	logic [2:0] config_mode_select;
	logic [7:0] rb_frame_addr;
	logic [63:0] ex;
	logic [63:0] exq[$];
	logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h18};
	logic [31:0] rv[5] = '{32'h0, 32'h0101, 32'h4, 32'h0, 32'h0};
	logic [2:0] md[7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
	int num_errors = 0;
	int num_checks = 0;
	int seed = 67473;
	int n;

	assign hready = hreadyout;
	cspc_ctrl #(.CLEAR_CYCLES(16)) DUT (.clock, .rst, .hsel(1'b1), .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp,
		.hrdata, .config_restart_n, .reset_pin_n, .readback_trigger_n,
		.done_in, .done_out, .done_oe_n, .init_in, .init_out, .init_oe_n,
		.config_mode_select, .mode_pullup_en, .config_clock_out,
		.config_clock_oe_n, .tdo_in, .scan_active, .readback_data_tdo,
		.rb_frame_addr, .rb_frame_data, .bscan_reset, .global_io_tristate,
		.user_oe_n, .programmable_io_oe_n, .programmable_io_pullup,
		.config_pins_released, .reset_pin_user, .logic_cell_gsr,
		.logic_cell_gsr_set);
	cspc_host host (.clock, .rst, .done_oe_n, .init_oe_n, .hold_done,
		.hold_init, .trig_req_n, .done_in, .init_in, .readback_trigger_n);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Reads note {mask, expected}; the monitor below compares.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [31:0] e);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		if (!w)
			exq.push_back({m, e});
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd_ph <= 1'b0;
	endtask

	always @(posedge clock) begin
		if (rd_ph && hreadyout) begin
			ex = exq.pop_front();
			chk(hrdata & ex[63:32], ex[31:0]);
			chk({hresp, init_out, done_out}, 32'h0);
		end
	end

	always @(posedge clock)
		tdo_in <= 1'($random(seed));

	task start(input logic [2:0] m, input logic rp);
		if (rp)
			reset_pin_n <= 1'b0;
		else
			config_restart_n <= 1'b0;
		config_mode_select <= m;
		hold_init <= 1'b1;
		repeat (4) @(posedge clock);
		chk(init_oe_n, 32'h0);
		chk(bscan_reset, !rp);
		reset_pin_n <= 1'b1;
		config_restart_n <= 1'b1;
		repeat (4) @(posedge clock);
		bus(1'b1, CSPC_CMD_ADDR, 32'h2, 32'h0, 32'h0);
		repeat (6) @(posedge clock);
		chk({init_oe_n, config_clock_oe_n}, 32'h3);
		hold_init <= 1'b0;
		repeat (6) @(posedge clock);
		config_mode_select <= ~m;
		bus(1'b0, CSPC_STATUS_ADDR, 0, 32'h7F, {25'h0, m, 4'h2});
		chk(config_clock_oe_n, !(m inside {CSPC_MODE_MSTR_SER,
			CSPC_MODE_MSTR_PAR, CSPC_MODE_MICRO, CSPC_MODE_ASYNC_PER}));
		trig_req_n <= 1'b0;
		repeat (4) @(posedge clock);
		chk(global_io_tristate, 32'h1);
		trig_req_n <= 1'b1;
	endtask

	initial begin
		#100000;
		num_errors++;
		conclude;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst, config_restart_n, reset_pin_n, trig_req_n} = 4'hF;
		{htrans, haddr, hwrite, hwdata, rd_ph, hold_done} = '0;
		{hold_init, scan_active, config_mode_select} = '0;
		user_oe_n = $random(seed);
		msk = $random(seed);
		rb_frame_data = $random(seed);
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		for (int i = 0; i < 5; i++)
			bus(1'b0, ra[i], 32'h0, 32'hFFFFFFFF, rv[i]);
		bus(1'b1, 8'h18, 32'hFFFFFFFF, 32'h0, 32'h0);
		bus(1'b0, 8'h18, 32'h0, 32'hFFFFFFFF, 32'h0);
		bus(1'b1, CSPC_CLKDIV_ADDR, 32'h0, 32'h0, 32'h0);
		bus(1'b1, CSPC_TIMING_ADDR, 32'h3030, 32'h0, 32'h0);
		bus(1'b1, CSPC_UNUSED_ADDR, msk, 32'h0, 32'h0);
		bus(1'b0, CSPC_UNUSED_ADDR, 32'h0, 32'hFFFFFFFF, msk);
		$display("test registers done");
		for (int i = 0; i < 7; i++)
			start(md[i], 1'(i));
		$display("test modes done");
		hold_done <= 1'b1;
		bus(1'b1, CSPC_CMD_ADDR, 32'h1, 32'h0, 32'h0);
		repeat (20) @(posedge clock);
		chk(done_oe_n, 32'h0);
		repeat (100) @(posedge clock);
		chk({done_oe_n, config_pins_released}, 32'h2);
		hold_done <= 1'b0;
		repeat (20) @(posedge clock);
		chk(config_pins_released, 32'h0);
		n = 0;
		while (config_pins_released !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
		chk(config_pins_released, 32'h1);
		chk(programmable_io_oe_n, user_oe_n | msk);
		chk(programmable_io_pullup & msk, msk);
		$display("test start-up done");
		bus(1'b1, CSPC_CTRL_ADDR, 32'hC, 32'h0, 32'h0);
		reset_pin_n <= 1'b0;
		repeat (4) @(posedge clock);
		chk({logic_cell_gsr, logic_cell_gsr_set}, 32'h3);
		reset_pin_n <= 1'b1;
		bus(1'b1, CSPC_CTRL_ADDR, 32'h2, 32'h0, 32'h0);
		reset_pin_n <= 1'b0;
		trig_req_n <= 1'b0;
		repeat (4) @(posedge clock);
		chk({reset_pin_user, logic_cell_gsr, global_io_tristate,
			config_pins_released}, 32'hB);
		reset_pin_n <= 1'b1;
		trig_req_n <= 1'b1;
		bus(1'b1, CSPC_CTRL_ADDR, 32'h1, 32'h0, 32'h0);
		trig_req_n <= 1'b0;
		repeat (6) @(posedge clock);
		bus(1'b0, CSPC_STATUS_ADDR, 0, 32'h00FF0300, 32'h100);
		chk(rb_frame_addr, 32'h0);
		trig_req_n <= 1'b1;
		repeat (8) @(posedge clock);
		bus(1'b0, CSPC_STATUS_ADDR, 32'h0, 32'h100, 32'h0);
		scan_active <= 1'b1;
		repeat (8) @(posedge clock);
		scan_active <= 1'b0;
		$display("test user phase done");
		conclude;
	end
endmodule
